// ==== rtl/ssp_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
module ssp_port #(
  parameter int SPI_HALF = `SSP_SPI_HALF,
  parameter int SPI_GAP = `SSP_SPI_GAP
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic peripheral_select_bit,
  input wire logic miso,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic ss_n
);
  // SPI half-bit and gap counter is eight bits wide
  generate
    if (SPI_HALF < 1 || SPI_HALF > 255 || SPI_GAP < 1 || SPI_GAP > 255) begin : g_bad
      $error("SPI_HALF and SPI_GAP must lie between 1 and 255");
    end
    // Four quarter-bits must make one bit of the divider base
    if (`SSP_I2C_DIV_BASE != 4 * `SSP_QTR_BASE) begin : g_bad_rate
      $error("two-wire quarter-bit base does not match the bit divider");
    end
  endgenerate

  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [7:0] mode_reg;
  logic [7:0] taddr_reg;
  logic tx_full, tx_empty_flag, rx_full_flag, rx_overflow_flag, noack_flag;
  logic rd_req;

  ssp_pkg::ssp_spi_state_e spi_st;
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  logic [2:0] spi_bit;
  logic [7:0] spi_cnt;
  logic spi_sclk, spi_sel_n;

  ssp_pkg::ssp_tw_state_e tw_st;
  ssp_pkg::ssp_tw_stage_e tw_stage;
  logic [8:0] tw_frame;
  logic [8:0] tw_rcv;
  logic [3:0] tw_bit;
  logic [1:0] tw_q;
  logic [6:0] tw_cnt;
  logic scl_rel, sda_rel;

  // Register address match, used by write and read decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addr_hit

  // Bus decode
  wire hit_tx = addr_hit(sfr_addr, `SSP_ADDR_TX);
  wire hit_rx = addr_hit(sfr_addr, `SSP_ADDR_RX);
  wire hit_mode = addr_hit(sfr_addr, `SSP_ADDR_MODE);
  wire hit_taddr = addr_hit(sfr_addr, `SSP_ADDR_TADDR);
  wire hit_stat = addr_hit(sfr_addr, `SSP_ADDR_STAT);
  wire wr_tx = sfr_wr && hit_tx;
  wire wr_mode = sfr_wr && hit_mode;
  wire wr_taddr = sfr_wr && hit_taddr;
  wire wr_stat = sfr_wr && hit_stat;
  wire rd_rx = sfr_rd && hit_rx;

  wire tw_en = mode_reg[`SSP_MODE_EN];
  wire [1:0] tw_div = mode_reg[`SSP_MODE_DIV_HI:`SSP_MODE_DIV_LO];
  wire ovw_en = mode_reg[`SSP_MODE_OVW];
  wire auto_ss = mode_reg[`SSP_MODE_AUTOSS];
  wire continuous_enable = taddr_reg[`SSP_CFG2_CONT];
  wire transfer_initiate_mode = taddr_reg[`SSP_CFG2_TRANSFER_INITIATE_MODE];
  wire mode_tx = transfer_initiate_mode;
  wire mode_cont = continuous_enable && transfer_initiate_mode;
  wire mode_rd = !continuous_enable && !transfer_initiate_mode;
  wire spi_on = !peripheral_select_bit;

  // SPI timing
  wire spi_tick = spi_cnt == 8'(SPI_HALF - 1);
  wire spi_byte_end = spi_st == ssp_pkg::SPI_SHIFT && spi_tick && spi_sclk && spi_bit == 3'd7;
  wire spi_start_tx = spi_st == ssp_pkg::SPI_IDLE && spi_on && mode_tx && tx_full;
  wire spi_start_rd = spi_st == ssp_pkg::SPI_IDLE && spi_on && mode_rd && rd_req;
  wire spi_chain = spi_byte_end && mode_cont && tx_full;
  wire spi_load = spi_start_tx || spi_chain;

  // Two-wire timing
  // quarter bit of 16*2^div/4 cycles
  // div 0 fast, div 3 standard
  wire [6:0] tw_qlen = 7'(`SSP_QTR_BASE << tw_div);
  wire tw_tick = tw_cnt == tw_qlen - 7'h01;
  wire tw_busy = tw_st != ssp_pkg::TW_IDLE;
  wire tw_go = wr_taddr && tw_en && peripheral_select_bit && !tw_busy;
  wire tw_frame_end = tw_st == ssp_pkg::TW_BIT && tw_tick && tw_q == 2'd3 && tw_bit == 4'd8;
  wire tw_acked = !tw_rcv[0];
  wire tw_next_wr = tw_frame_end && tw_acked && tx_full &&
                    (tw_stage == ssp_pkg::TW_WRITE ||
                     (tw_stage == ssp_pkg::TW_ADDR && !taddr_reg[0]));
  wire tw_nack = tw_frame_end && !tw_acked && tw_stage != ssp_pkg::TW_READ;
  wire tw_rx_store = tw_frame_end && tw_stage == ssp_pkg::TW_READ;

  // Shared event pulses
  wire spi_rx_store = spi_byte_end;
  wire rx_store = spi_rx_store || tw_rx_store;
  // SPI byte complete at its last falling edge
  wire [7:0] rx_new = tw_rx_store ? tw_rcv[8:1] : sh_in;
  wire tx_take = spi_load || tw_next_wr;

  // Software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_buf <= `SSP_REG_RESET;
      mode_reg <= `SSP_REG_RESET;
      taddr_reg <= `SSP_REG_RESET;
    end else begin
      if (wr_tx) begin
        tx_buf <= sfr_wdata;
      end
      if (wr_mode) begin
        mode_reg <= sfr_wdata;
      end
      if (wr_taddr) begin
        taddr_reg <= sfr_wdata;
      end
    end
  end

  // Flags, set wins over clear, except rd_req where the read start clears it
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_full <= 1'b0;
      tx_empty_flag <= 1'b0;
      rx_full_flag <= 1'b0;
      rx_overflow_flag <= 1'b0;
      noack_flag <= 1'b0;
      rx_buf <= `SSP_REG_RESET;
      rd_req <= 1'b0;
    end else begin
      // Refill written at a load edge stays pending
      tx_full <= wr_tx ? 1'b1 : (tx_take ? 1'b0 : tx_full);
      tx_empty_flag <= tx_take ? 1'b1 :
                       ((wr_tx || (wr_stat && !sfr_wdata[`SSP_ST_TXEMPTY])) ? 1'b0 : tx_empty_flag);
      rx_full_flag <= rx_store ? 1'b1 :
                      ((rd_rx || (wr_stat && !sfr_wdata[`SSP_ST_RXFULL])) ? 1'b0 : rx_full_flag);
      rx_overflow_flag <= (rx_store && rx_full_flag && !rd_rx) ? 1'b1 :
                          ((wr_stat && !sfr_wdata[`SSP_ST_RXOF]) ? 1'b0 : rx_overflow_flag);
      noack_flag <= tw_nack ? 1'b1 :
                    ((wr_stat && !sfr_wdata[`SSP_ST_NOACK]) ? 1'b0 : noack_flag);
      if (rx_store && (!rx_full_flag || rd_rx || ovw_en)) begin
        rx_buf <= rx_new;
      end
      rd_req <= spi_start_rd ? 1'b0 : ((rd_rx && mode_rd && spi_on) ? 1'b1 : rd_req);
    end
  end

  wire [7:0] stat_val = {tw_busy, noack_flag, rx_overflow_flag, rx_full_flag,
                         tx_empty_flag, tx_full, 2'b00};
  wire [7:0] rd_mux = hit_rx ? rx_buf :
                      hit_mode ? mode_reg :
                      hit_taddr ? taddr_reg :
                      hit_stat ? stat_val : 8'h00;

  always_ff @(posedge clock) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      // Held until the next read
      sfr_rdata <= rd_mux;
    end
  end

  // SPI master engine, clock idles low
  always_ff @(posedge clock) begin
    if (rst) begin
      spi_st <= ssp_pkg::SPI_IDLE;
      sh_out <= 8'h00;
      sh_in <= 8'h00;
      spi_bit <= 3'd0;
      spi_cnt <= 8'h00;
      spi_sclk <= 1'b0;
      spi_sel_n <= 1'b1;
    end else begin
      case (spi_st)
        ssp_pkg::SPI_IDLE: begin
          spi_cnt <= 8'h00;
          spi_sclk <= 1'b0;
          spi_bit <= 3'd0;
          if (spi_start_tx || spi_start_rd) begin
            sh_out <= spi_start_tx ? tx_buf : 8'hff;
            spi_sel_n <= !auto_ss;
            spi_st <= ssp_pkg::SPI_SHIFT;
          end
        end
        ssp_pkg::SPI_SHIFT: begin
          spi_cnt <= spi_tick ? 8'h00 : spi_cnt + 8'h01;
          if (spi_tick && !spi_sclk) begin
            spi_sclk <= 1'b1;
            sh_in <= {sh_in[6:0], miso};
          end else if (spi_tick) begin
            spi_sclk <= 1'b0;
            spi_bit <= spi_bit + 3'd1;
            sh_out <= {sh_out[6:0], 1'b0};
            if (spi_byte_end) begin
              if (spi_chain) begin
                sh_out <= tx_buf;
              end else begin
                // release at byte end unless continuous mode has the buffer full
                spi_sel_n <= 1'b1;
                spi_st <= ssp_pkg::SPI_GAP;
              end
            end
          end
        end
        ssp_pkg::SPI_GAP: begin
          spi_cnt <= spi_cnt + 8'h01;
          if (spi_cnt == 8'(SPI_GAP - 1)) begin
            spi_cnt <= 8'h00;
            spi_st <= ssp_pkg::SPI_IDLE;
          end
        end
        default: begin
          spi_st <= ssp_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tw_st <= ssp_pkg::TW_IDLE;
      tw_stage <= ssp_pkg::TW_ADDR;
      tw_frame <= 9'h1ff;
      tw_rcv <= 9'h000;
      tw_bit <= 4'd0;
      tw_q <= 2'd0;
      tw_cnt <= 7'h00;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
    end else begin
      tw_cnt <= (tw_tick || !tw_busy) ? 7'h00 : tw_cnt + 7'h01;
      if (tw_busy && tw_tick) begin
        tw_q <= tw_q + 2'd1;
      end
      case (tw_st)
        ssp_pkg::TW_IDLE: begin
          // Both lines released while idle
          tw_q <= 2'd0;
          scl_rel <= 1'b1;
          sda_rel <= 1'b1;
          if (tw_go) begin
            tw_frame <= {sfr_wdata, 1'b1};
            tw_stage <= ssp_pkg::TW_ADDR;
            tw_st <= ssp_pkg::TW_START;
          end
        end
        ssp_pkg::TW_START: begin
          if (tw_tick && tw_q == 2'd1) begin
            sda_rel <= 1'b0;
          end else if (tw_tick && tw_q == 2'd3) begin
            scl_rel <= 1'b0;
            tw_bit <= 4'd0;
            tw_st <= ssp_pkg::TW_BIT;
          end
        end
        ssp_pkg::TW_BIT: begin
          if (tw_tick) begin
            case (tw_q)
              2'd0: sda_rel <= tw_frame[8];
              2'd1: scl_rel <= 1'b1;
              2'd2: tw_rcv <= {tw_rcv[7:0], data_in};
              default: begin
                scl_rel <= 1'b0;
                tw_frame <= {tw_frame[7:0], 1'b1};
                tw_bit <= tw_bit + 4'd1;
              end
            endcase
          end
          if (tw_frame_end) begin
            tw_bit <= 4'd0;
            if (tw_next_wr) begin
              tw_frame <= {tx_buf, 1'b1};
              tw_stage <= ssp_pkg::TW_WRITE;
            end else if (tw_stage == ssp_pkg::TW_ADDR && tw_acked && taddr_reg[0]) begin
              tw_frame <= 9'h1ff;
              tw_stage <= ssp_pkg::TW_READ;
            end else begin
              tw_st <= ssp_pkg::TW_STOP;
            end
          end
        end
        ssp_pkg::TW_STOP: begin
          if (tw_tick && tw_q == 2'd0) begin
            sda_rel <= 1'b0;
          end else if (tw_tick && tw_q == 2'd1) begin
            scl_rel <= 1'b1;
          end else if (tw_tick && tw_q == 2'd2) begin
            sda_rel <= 1'b1;
          end else if (tw_tick && tw_q == 2'd3) begin
            tw_st <= ssp_pkg::TW_IDLE;
          end
        end
        default: begin
          tw_st <= ssp_pkg::TW_IDLE;
        end
      endcase
    end
  end

  assign data_out = peripheral_select_bit ? 1'b0 : sh_out[7];
  assign data_oe_n = peripheral_select_bit ? sda_rel : 1'b0;
  assign sclk_out = peripheral_select_bit ? 1'b0 : spi_sclk;
  assign sclk_oe_n = peripheral_select_bit ? scl_rel : 1'b0;
  assign ss_n = spi_sel_n;

  // Slave mode not built, clock input unused
  wire unused_ok = sclk_in;
endmodule : ssp_port
`default_nettype wire

// ==== rtl/ssp_consts.svh ====
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADDR_TX 8'h9a
`define SSP_ADDR_RX 8'h9b
`define SSP_ADDR_MODE 8'he8
`define SSP_ADDR_TADDR 8'he9
`define SSP_ADDR_STAT 8'hea
`define SSP_MODE_EN 7
`define SSP_MODE_DIV_HI 6
`define SSP_MODE_DIV_LO 5
`define SSP_MODE_OVW 1
`define SSP_MODE_AUTOSS 0
`define SSP_CFG2_CONT 7
`define SSP_CFG2_TRANSFER_INITIATE_MODE 0
`define SSP_ST_BUSY 7
`define SSP_ST_NOACK 6
`define SSP_ST_RXOF 5
`define SSP_ST_RXFULL 4
`define SSP_ST_TXEMPTY 3
`define SSP_ST_TXFULL 2
`define SSP_REG_RESET 8'h00
`define SSP_I2C_DIV_BASE 16
`define SSP_QTR_BASE 7'h04
`define SSP_SPI_HALF 4
`define SSP_SPI_GAP 8
`endif

// ==== rtl/ssp_pkg.sv ====
package ssp_pkg;
  typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_GAP} ssp_spi_state_e;
  typedef enum logic [1:0] {TW_IDLE, TW_START, TW_BIT, TW_STOP} ssp_tw_state_e;
  typedef enum logic [1:0] {TW_ADDR, TW_WRITE, TW_READ} ssp_tw_stage_e;
endpackage : ssp_pkg

// ==== verification/ssp_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_port_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic peripheral_select_bit,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic sclk_out,
  input wire logic sclk_oe_n,
  input wire logic ss_n
);
  logic [2:0] rise_cnt;
  logic sclk_prev;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Clock rises seen while selected
  always_ff @(posedge clock) begin
    sclk_prev <= sclk_out;
    if (rst || ss_n) begin
      rise_cnt <= 3'h0;
    end else if (sclk_out && !sclk_prev) begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end
  a_reset_outputs: assert property (disable iff (1'b0) rst |=> ss_n && !sclk_out &&
    sfr_rdata == 8'h00) else $error("outputs not cleared by reset");
  a_spi_pins_driven: assert property (!peripheral_select_bit |-> !data_oe_n && !sclk_oe_n)
    else $error("serial pins not driven in spi mode");
  a_two_wire_open: assert property (peripheral_select_bit && $past(peripheral_select_bit)
    |-> !data_out && !sclk_out) else $error("two-wire line pushed high");
  a_byte_whole: assert property ($rose(ss_n) |-> rise_cnt == 3'h0)
    else $error("select released inside a byte");
  a_idle_gap: assert property ($rose(ss_n) |-> ss_n [*2])
    else $error("no idle gap after transfer");
  a_tx_read_zero: assert property (sfr_rd && sfr_addr == 8'h9a |=> sfr_rdata == 8'h00)
    else $error("transmit buffer readable");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  a_sclk_idle_low: assert property ($rose(ss_n) |-> !sclk_out)
    else $error("clock not idle low at deselect");
  c_byte_done: cover property ($rose(ss_n));
  c_long_select: cover property (!ss_n [*8] ##1 !ss_n [*8] ##1 !ss_n [*8]);
  c_two_wire: cover property (peripheral_select_bit && !sclk_oe_n);
endmodule : ssp_port_properties
bind ssp_port ssp_port_properties u_ssp_port_properties (.clock(clock), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .peripheral_select_bit(peripheral_select_bit), .data_out(data_out),
  .data_oe_n(data_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .ss_n(ss_n));
`default_nettype wire

// ==== verification/ssp_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
  input wire logic sclk_out,
  input wire logic sclk_oe_n,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic ss_n,
  input wire logic [7:0] reply,
  output logic miso,
  output logic data_in,
  output logic sclk_in,
  output logic [7:0] received
);
  logic [7:0] shifter = 8'h00;
  logic [7:0] captured = 8'h00;
  logic last_bit = 1'b0;
  // Shift register slave, captured on rising clock
  always @(negedge ss_n) shifter <= reply;
  always @(posedge sclk_out) if (!ss_n) captured <= {captured[6:0], data_out};
  // Echoes each captured bit back out on the falling clock
  always @(negedge sclk_out) if (!ss_n) shifter <= {shifter[6:0], captured[0]};
  always @(posedge ss_n) begin
    received <= captured;
    last_bit <= shifter[7];
  end
  assign miso = ss_n ? ~last_bit : shifter[7];
  assign data_in = data_oe_n ? 1'b1 : data_out;
  assign sclk_in = sclk_oe_n ? 1'b1 : sclk_out;
endmodule : ssp_slave_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst, sfr_wr, sfr_rd, peripheral_select_bit, miso, data_in, data_out;
  logic data_oe_n, sclk_in, sclk_out, sclk_oe_n, ss_n;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, reply, received, d;
  int failures = 0;
  int comparisons = 0;
  int rises;
  int sel_rises;
  ssp_port #(.SPI_HALF(1), .SPI_GAP(2)) u_ssp_port (.clock(clock), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .peripheral_select_bit(peripheral_select_bit), .miso(miso),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .sclk_in(sclk_in),
    .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .ss_n(ss_n));
  ssp_slave_model u_ssp_slave_model (.sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .ss_n(ss_n), .reply(reply), .miso(miso),
    .data_in(data_in), .sclk_in(sclk_in), .received(received));
  // Clock rises while the slave is selected
  always @(posedge sclk_out) begin
    if (!ss_n) begin
      sel_rises++;
    end
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task give_verdict;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask : rd
  task wait_ss(input logic v);
    int n;
    n = 0;
    while (ss_n !== v && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n >= 300) begin
      failures++;
      give_verdict;
    end
  endtask : wait_ss
  task test_reset;
    rd(8'hea, d);
    check(d, 8'h00);
    rd(8'he8, d);
    check(d, 8'h00);
    rd(8'h9a, d);
    check(d, 8'h00);
    check({7'h00, ss_n}, 8'h01);
    $display("test reset done");
  endtask : test_reset
  task test_single_read;
    wr(8'he8, 8'h01);
    wr(8'he9, 8'h00);
    reply = 8'ha5;
    rd(8'h9b, d);
    wait_ss(1'b0);
    wait_ss(1'b1);
    check(received, 8'hff);
    rd(8'hea, d);
    check(d, 8'h10);
    reply = 8'h3c;
    rd(8'h9b, d);
    check(d, 8'ha5);
    wait_ss(1'b0);
    wait_ss(1'b1);
    $display("test single read done");
  endtask : test_single_read
  task test_single_write;
    wr(8'he9, 8'h01);
    reply = 8'h5a;
    wr(8'h9a, 8'h81);
    wait_ss(1'b0);
    wait_ss(1'b1);
    check(received, 8'h81);
    rd(8'hea, d);
    check(d, 8'h38);
    rd(8'h9b, d);
    check(d, 8'h3c);
    repeat (20) @(negedge clock);
    check({7'h00, ss_n}, 8'h01);
    $display("test single write done");
  endtask : test_single_write
  task test_continuous;
    wr(8'he8, 8'h03);
    wr(8'he9, 8'h81);
    wr(8'hea, 8'h00);
    reply = 8'h96;
    rises = sel_rises;
    wr(8'h9a, 8'h11);
    wait_ss(1'b0);
    wr(8'h9a, 8'h22);
    wait_ss(1'b1);
    check(8'(sel_rises - rises), 8'h10);
    check(received, 8'h22);
    rd(8'h9b, d);
    check(d, 8'h11);
    rd(8'hea, d);
    check(d & 8'h28, 8'h28);
    $display("test continuous done");
  endtask : test_continuous
  task test_two_wire;
    int n;
    int edges;
    logic prev;
    logic [7:0] period;
    wr(8'hea, 8'h00);
    peripheral_select_bit = 1'b1;
    for (int i = 0; i < 4; i += 3) begin
      wr(8'he8, {1'b1, i[1:0], 5'h00});
      wr(8'he9, 8'ha0);
      rd(8'hea, d);
      check(d & 8'h80, 8'h80);
      n = 0;
      edges = 0;
      period = 8'h00;
      prev = sclk_in;
      while (edges < 2 && n < 600) begin
        @(negedge clock);
        if (sclk_in && !prev) edges++;
        if (edges == 1) period++;
        prev = sclk_in;
        n++;
      end
      if (edges < 2) begin
        failures++;
        give_verdict;
      end
      check(period, 8'h10 << i);
      n = 0;
      while (d[7] && n < 1000) begin
        rd(8'hea, d);
        n++;
      end
      if (d[7]) begin
        failures++;
        give_verdict;
      end
      check(d & 8'hc0, 8'h40);
      wr(8'hea, 8'h00);
    end
    $display("test two wire done");
  endtask : test_two_wire
  initial begin
    rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    peripheral_select_bit = 1'b0;
    reply = 8'h00;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    test_reset;
    test_single_read;
    test_single_write;
    test_continuous;
    test_two_wire;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
